// ---- rtl/interrupt_enable_register_zero.sv ----
// Enable register zero of the interrupt controller with Avalon-MM slave.
// Assumes pending flags come from peripheral logic on core_clk and the
// gated requests go to the arbitration logic on the same clock.
//
// The address map and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps
module interrupt_enable_register_zero (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire irq_enable_pkg::source_vec_t source_flag,
	output irq_enable_pkg::source_vec_t source_req
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	irq_enable_pkg::source_vec_t enable_q;
	irq_enable_pkg::source_vec_t enable_d;
	logic waitrequest_q;
	logic [31:0] readdata_q;
	logic [31:0] readdata_d;
	logic request;
	logic accept;
	logic ack;
	logic [15:0] req_vec;
	logic [15:0] enable_vec;

	assign request = avs_read | avs_write;
	// First edge of a request: data is prepared, wait drops
	assign accept = request & waitrequest_q;
	// Second edge: master samples wait low, write commits here
	assign ack = request & ~waitrequest_q;

	// ----------------------------------------------------------------
	// Bus handshake
	// ----------------------------------------------------------------
	// Fixed one wait state keeps read data off the combinational path
	always_ff @(posedge core_clk) begin
		if (rst) begin
			waitrequest_q <= 1'b1;
		end else if (accept) begin
			waitrequest_q <= 1'b0;
		end else begin
			waitrequest_q <= 1'b1;
		end
	end

	assign avs_waitrequest = waitrequest_q;

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	always_comb begin
		readdata_d = irq_enable_pkg::READ_UNMAPPED;
		case (avs_address)
			irq_enable_pkg::OFFS_ENABLE: begin
				readdata_d = {16'h0000,
					16'(enable_q) & irq_enable_pkg::IMPL_MASK};
			end
			irq_enable_pkg::OFFS_PENDING: begin
				readdata_d = {16'h0000,
					16'(source_flag) & irq_enable_pkg::IMPL_MASK};
			end
			irq_enable_pkg::OFFS_REQUEST: begin
				readdata_d = {16'h0000, 16'(source_req)};
			end
			default: begin
				readdata_d = irq_enable_pkg::READ_UNMAPPED;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			readdata_q <= 32'h0000_0000;
		end else if (accept && avs_read) begin
			readdata_q <= readdata_d;
		end
	end

	assign avs_readdata = readdata_q;

	// ----------------------------------------------------------------
	// Enable register
	// ----------------------------------------------------------------
	always_comb begin
		enable_d = enable_q;
		if (avs_byteenable[0]) begin
			enable_d[7:0] = avs_writedata[7:0];
		end
		if (avs_byteenable[1]) begin
			enable_d[15:8] = avs_writedata[15:8];
		end
		// Unimplemented positions never store a one
		enable_d = irq_enable_pkg::source_vec_t'(16'(enable_d)
			& irq_enable_pkg::IMPL_MASK);
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			enable_q <= irq_enable_pkg::source_vec_t'(
				irq_enable_pkg::ENABLE_RESET);
		end else if (ack && avs_write
			&& avs_address == irq_enable_pkg::OFFS_ENABLE) begin
			enable_q <= enable_d;
		end
	end

	// ----------------------------------------------------------------
	// Request gating
	// ----------------------------------------------------------------
	// One register stage: requests follow flags and enables by one cycle
	enable_gate #(
		.WIDTH(irq_enable_pkg::REG_WIDTH),
		.IMPL_MASK(irq_enable_pkg::IMPL_MASK)
	) u_gate (
		.core_clk(core_clk),
		.rst(rst),
		.flag(16'(source_flag)),
		.enable(16'(enable_q)),
		.req(req_vec)
	);

	assign source_req = irq_enable_pkg::source_vec_t'(req_vec);
	assign enable_vec = 16'(enable_q);

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	// Edge that leaves reset still sees pre-reset enables in $past
	a_nvm_gate: assert property (
		!$past(rst) |->
		source_req.nonvolatile_done ==
		$past(source_flag.nonvolatile_done && enable_q.nonvolatile_done)
	) else $error("nonvolatile request not gated by its enable");

	a_nvm_blocked: assert property (
		!enable_q.nonvolatile_done && $stable(enable_q)
		|=> !source_req.nonvolatile_done
	) else $error("nonvolatile request passed while disabled");

	a_tx_gate: assert property (
		source_flag.serial_tx && enable_q.serial_tx
		|=> source_req.serial_tx
	) else $error("transmitter request lost while enabled");

	a_tx_blocked: assert property (
		!enable_q.serial_tx |=> !source_req.serial_tx
	) else $error("transmitter request passed while disabled");

	a_compare_one: assert property (
		!$past(rst) |->
		source_req.compare_one ==
		$past(source_flag.compare_one & enable_q.compare_one)
	) else $error("compare one request gating wrong");

	a_capture_one: assert property (
		source_flag.capture_one && !enable_q.capture_one
		|=> !source_req.capture_one
	) else $error("capture request raised while disabled");

	a_capture_pass: assert property (
		source_flag.capture_one && enable_q.capture_one
		|=> source_req.capture_one
	) else $error("capture request lost while enabled");

	a_ext_zero: assert property (
		source_req.external_zero |->
		$past(source_flag.external_zero) && $past(enable_q.external_zero)
	) else $error("external zero request without flag and enable");

	a_all_polarity: assert property (
		!$past(rst) |->
		16'(source_req) == ($past(16'(source_flag)) & $past(16'(enable_q))
			& irq_enable_pkg::IMPL_MASK)
	) else $error("request vector differs from flag and enable");

	a_twowire_gate: assert property (
		!$past(rst) |->
		source_req.twowire_slave ==
		$past(source_flag.twowire_slave & enable_q.twowire_slave)
	) else $error("two-wire slave request gating wrong");

	a_bit_four_zero: assert property (
		!enable_q.unused_4 && !source_req.unused_4
		&& !enable_q.unused_14 && !enable_q.unused_15
	) else $error("unimplemented enable position holds a one");

	a_unimpl_request: assert property (
		!source_req.unused_15 && !source_req.unused_14
	) else $error("request raised at an unimplemented position");

	a_remaining_gate: assert property (
		!$past(rst) |->
		{source_req.converter_done, source_req.serial_rx,
			source_req.sync_serial, source_req.timer_three,
			source_req.timer_two, source_req.compare_two,
			source_req.timer_one} ==
		$past({source_flag.converter_done & enable_q.converter_done,
			source_flag.serial_rx & enable_q.serial_rx,
			source_flag.sync_serial & enable_q.sync_serial,
			source_flag.timer_three & enable_q.timer_three,
			source_flag.timer_two & enable_q.timer_two,
			source_flag.compare_two & enable_q.compare_two,
			source_flag.timer_one & enable_q.timer_one})
	) else $error("remaining source gated at wrong position");

	a_write_commit: assert property (
		ack && avs_write && avs_address == irq_enable_pkg::OFFS_ENABLE
		&& avs_byteenable[1:0] == 2'b11
		|=> 16'(enable_q) ==
			($past(avs_writedata[15:0]) & irq_enable_pkg::IMPL_MASK)
	) else $error("enable write did not commit");

	a_wait_one_cycle: assert property (
		accept |=> !avs_waitrequest ##1 avs_waitrequest
	) else $error("wait state not exactly one cycle");

	a_read_back: assert property (
		accept && avs_read && avs_address == irq_enable_pkg::OFFS_ENABLE
		|=> avs_readdata == {16'h0000, $past(16'(enable_q))}
	) else $error("enable read back wrong");

	a_no_write_stable: assert property (
		!(ack && avs_write) |=> $stable(enable_q)
	) else $error("enable changed without a write");

	// ----------------------------------------------------------------
	// Bus view assertions
	// ----------------------------------------------------------------
	a_read_pending: assert property (
		accept && avs_read && avs_address == irq_enable_pkg::OFFS_PENDING
		|=> avs_readdata == {16'h0000,
			$past(16'(source_flag)) & irq_enable_pkg::IMPL_MASK}
	) else $error("pending view read back wrong");

	// Request view shows the gated vector standing at accept
	a_read_request: assert property (
		accept && avs_read && avs_address == irq_enable_pkg::OFFS_REQUEST
		|=> avs_readdata == {16'h0000, $past(16'(source_req))}
	) else $error("request view read back wrong");

	a_read_unmapped: assert property (
		accept && avs_read
		&& avs_address != irq_enable_pkg::OFFS_ENABLE
		&& avs_address != irq_enable_pkg::OFFS_PENDING
		&& avs_address != irq_enable_pkg::OFFS_REQUEST
		|=> avs_readdata == irq_enable_pkg::READ_UNMAPPED
	) else $error("unmapped read returned data");

	a_write_elsewhere: assert property (
		ack && avs_write && avs_address != irq_enable_pkg::OFFS_ENABLE
		|=> $stable(enable_q)
	) else $error("write to another offset changed the enables");

	a_readdata_hold: assert property (
		!(accept && avs_read) |=> $stable(avs_readdata)
	) else $error("read data moved without a read");

	a_wait_idle: assert property (
		!request |=> avs_waitrequest
	) else $error("wait request low while idle");

	// Values that leave reset must be the cleared ones
	a_reset_state: assert property (
		$past(rst) |-> avs_waitrequest && avs_readdata == 32'h0000_0000
		&& 16'(source_req) == 16'h0000
		&& 16'(enable_q) == irq_enable_pkg::ENABLE_RESET
	) else $error("state after reset not cleared");

	// Same polarity at every implemented position
	for (genvar b = 0; b < irq_enable_pkg::REG_WIDTH; b++) begin : g_bit_chk
		if (irq_enable_pkg::IMPL_MASK[b]) begin : g_impl
			a_bit_polarity: assert property (
				!enable_vec[b] |=> !req_vec[b]
			) else $error("disabled position raised a request");
		end
	end

	c_read_pending: cover property (
		ack && avs_read && avs_address == irq_enable_pkg::OFFS_PENDING
	);
	c_write_enable: cover property (
		ack && avs_write && avs_address == irq_enable_pkg::OFFS_ENABLE
	);
	c_read_request: cover property (
		ack && avs_read && avs_address == irq_enable_pkg::OFFS_REQUEST
		&& avs_readdata != 32'h0000_0000
	);
	c_nvm_pass: cover property (
		source_flag.nonvolatile_done && enable_q.nonvolatile_done
		##1 source_req.nonvolatile_done
	);
	c_masked_flag: cover property (
		source_flag.external_zero && !enable_q.external_zero
	);

endmodule : interrupt_enable_register_zero

// ---- rtl/irq_enable_pkg.sv ----
// Constants, register map and source layout for the enable register block.
// Assumes a single 25 MHz core clock and an Avalon-MM master on the bus.
//
// Notes on behaviour
// - Nonvolatile memory done request passes only while enable bit 12 is 1.
// - Serial transmitter request passes while bit 10 is 1, blocked at 0.
// - Output compare one request passes only while bit 2 is 1.
// - Input capture one request raises an interrupt only while bit 1 is set.
// - External interrupt zero request passes only while bit 0 is 1.
// - Every implemented enable bit: stored 1 enables, stored 0 disables.
// - Two-wire slave event request gated by bit 13, 1 enables.
package irq_enable_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses, one aligned word each)
	// ----------------------------------------------------------------
	localparam logic [3:0] OFFS_ENABLE = 4'h0;
	localparam logic [3:0] OFFS_PENDING = 4'h4;
	localparam logic [3:0] OFFS_REQUEST = 4'h8;

	localparam int REG_WIDTH = 16;
	localparam logic [15:0] ENABLE_RESET = 16'h0000;
	// Bits 15 and 14 belong to the part of the register left out here
	localparam logic [15:0] IMPL_MASK = 16'h3fef;
	localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Bit positions
	// ----------------------------------------------------------------
	localparam int BIT_TWOWIRE_SLAVE = 13;
	localparam int BIT_NONVOLATILE_DONE = 12;
	localparam int BIT_CONVERTER_DONE = 11;
	localparam int BIT_SERIAL_TX = 10;
	localparam int BIT_SERIAL_RX = 9;
	localparam int BIT_SYNC_SERIAL = 8;
	localparam int BIT_TIMER_THREE = 7;
	localparam int BIT_TIMER_TWO = 6;
	localparam int BIT_COMPARE_TWO = 5;
	localparam int BIT_UNUSED_FOUR = 4;
	localparam int BIT_TIMER_ONE = 3;
	localparam int BIT_COMPARE_ONE = 2;
	localparam int BIT_CAPTURE_ONE = 1;
	localparam int BIT_EXTERNAL_ZERO = 0;

	// One field per source, MSB first, matching the bit positions above
	typedef struct packed {
		logic unused_15;
		logic unused_14;
		logic twowire_slave;
		logic nonvolatile_done;
		logic converter_done;
		logic serial_tx;
		logic serial_rx;
		logic sync_serial;
		logic timer_three;
		logic timer_two;
		logic compare_two;
		logic unused_4;
		logic timer_one;
		logic compare_one;
		logic capture_one;
		logic external_zero;
	} source_vec_t;

endpackage : irq_enable_pkg

// ---- rtl/enable_gate.sv ----
// Per-source AND of pending flag and enable bit, registered.
// Assumes flag and enable come from logic on the same clock.
`timescale 1ns/1ps
module enable_gate #(
	parameter int WIDTH = 16,
	parameter logic [WIDTH-1:0] IMPL_MASK = '1
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] flag,
	input wire logic [WIDTH-1:0] enable,
	output logic [WIDTH-1:0] req
);

	// ----------------------------------------------------------------
	// Gate per bit
	// ----------------------------------------------------------------
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		always_ff @(posedge core_clk) begin
			if (rst) begin
				req[i] <= 1'b0;
			end else begin
				// Stored 1 passes, stored 0 blocks; unimplemented never pass
				req[i] <= flag[i] & enable[i] & IMPL_MASK[i];
			end
		end
	end

endmodule : enable_gate

// ---- dv/interrupt_enable_register_zero_bench.sv ----
// Self-checking bench for the enable register block: Avalon-MM master
// tasks, a bench model of the enable bits and the gated request path.
// Assumes the design answers every access with waitrequest after accept.
`timescale 1ns/1ps
module interrupt_enable_register_zero_bench;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	irq_enable_pkg::source_vec_t source_flag = '0;
	irq_enable_pkg::source_vec_t source_req;
	logic [15:0] en_m = 16'h0;
	logic [15:0] exp_q = 16'h0;
	logic [15:0] pend_m = 16'h0;
	logic [15:0] reqv_m = 16'h0;
	logic [15:0] mask;
	logic [31:0] rd;
	logic [31:0] d;
	logic [3:0] be;
	integer errors = 0;
	integer num_checks = 0;
	integer cycles = 0;
	integer seed = 32'h20720ed2;
	integer i;

	assign mask = irq_enable_pkg::IMPL_MASK;

	always #20 core_clk = ~core_clk;

	interrupt_enable_register_zero u_dut (
		.core_clk(core_clk),
		.rst(rst),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.source_flag(source_flag),
		.source_req(source_req)
	);

	// ----------------------------------------------------------------
	// Reporting
	// ----------------------------------------------------------------
	task complete_run;
		$display("Checks %0d, errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : complete_run

	task check(input logic [31:0] got, input logic [31:0] exp_v,
		input string what);
		num_checks++;
		if (got !== exp_v) begin
			errors++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got,
				exp_v);
		end
	endtask : check

	// ----------------------------------------------------------------
	// Avalon-MM master
	// ----------------------------------------------------------------
	// Entered right after a rising edge; leaves the request up so that
	// back-to-back accesses never assign a strobe twice in one step.
	task bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
		input logic [3:0] bel, output logic [31:0] q);
		logic done;
		avs_address <= a;
		avs_writedata <= wd;
		avs_byteenable <= bel;
		avs_read <= !wr;
		avs_write <= wr;
		done = 1'b0;
		while (!done) begin
			// Value seen before the edge is what that edge samples
			@(negedge core_clk);
			done = !avs_waitrequest;
			q = avs_readdata;
			@(posedge core_clk);
		end
		if (wr && a == 4'h0)
			en_m <= {bel[1] ? wd[15:8] : en_m[15:8],
				bel[0] ? wd[7:0] : en_m[7:0]} & mask;
	endtask : bus

	task idle;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge core_clk);
	endtask : idle

	// ----------------------------------------------------------------
	// Flags and request model
	// ----------------------------------------------------------------
	always @(posedge core_clk) begin
		source_flag <= irq_enable_pkg::source_vec_t'(16'($random(seed)));
		if (rst) begin
			exp_q <= 16'h0;
		end else begin
			exp_q <= source_flag & en_m & mask;
			// Read views freeze at the accept edge
			if (avs_read && avs_waitrequest) begin
				pend_m <= source_flag & mask;
				reqv_m <= exp_q;
			end
		end
	end

	always @(negedge core_clk) begin
		if (!rst)
			check({16'h0, source_req}, {16'h0, exp_q}, "gated req");
	end

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 5000) begin
			errors++;
			$display("MISMATCH %0t timeout", $time);
			complete_run();
		end
	end

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		bus(1'b0, 4'h0, 32'h0, 4'h0, rd);
		check(rd, 32'h0, "reset value");
		for (i = 0; i < 16; i++) begin
			bus(1'b1, 4'h0, 32'h1 << i, 4'h3, rd);
			bus(1'b0, 4'h0, 32'h0, 4'h0, rd);
			check(rd, {16'h0, en_m}, "single bit");
		end
		bus(1'b1, 4'h0, 32'hffff_ffff, 4'hf, rd);
		bus(1'b0, 4'h0, 32'h0, 4'h0, rd);
		check(rd, 32'h0000_3fef, "all ones");
		bus(1'b1, 4'h4, 32'h0, 4'hf, rd);
		bus(1'b1, 4'h8, 32'h0, 4'hf, rd);
		bus(1'b1, 4'hc, 32'h0, 4'hf, rd);
		bus(1'b0, 4'h0, 32'h0, 4'h0, rd);
		check(rd, 32'h0000_3fef, "ignored writes");
		bus(1'b0, 4'hc, 32'h0, 4'h0, rd);
		check(rd, 32'h0, "unmapped read");
		for (i = 0; i < 24; i++) begin
			d = $random(seed);
			be = 4'($random(seed));
			bus(1'b1, 4'h0, d, be, rd);
			idle();
			idle();
			bus(1'b0, 4'h0, 32'h0, 4'h0, rd);
			check(rd, {16'h0, en_m}, "random write");
		end
		bus(1'b1, 4'h0, 32'h0000_ffff, 4'h3, rd);
		for (i = 0; i < 8; i++) begin
			bus(1'b0, 4'h4, 32'h0, 4'h0, rd);
			check(rd, {16'h0, pend_m}, "pending view");
			bus(1'b0, 4'h8, 32'h0, 4'h0, rd);
			check(rd, {16'h0, reqv_m}, "request view");
		end
		idle();
		rst <= 1'b1;
		en_m <= 16'h0;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		bus(1'b0, 4'h0, 32'h0, 4'h0, rd);
		check(rd, 32'h0, "second reset");
		idle();
		repeat (5) @(posedge core_clk);
		complete_run();
	end
endmodule : interrupt_enable_register_zero_bench
